// File: logic/sci_top.v
// serial command interpreter: parser, responder and line framing
`timescale 1ns/1ns
`include "sci_consts.vh"
// Summary of operation
// - serial 9600 baud, 8N1, no flow control
// - same protocol offered on network port 23
// - mode selects native or four legacy variants
// - every reply ends with one carriage return
// - successful write answers exclamation mark
// - read returns value as ASCII text
// - bad command ?10, bad argument ?11
// - phase-restricted command outside phase gives ?14
// - recipe select, standby only, answers !
// - dry weight 1 to 32000, standby only
// - status readings answered in any phase
// - full log streamed tab separated
// - last record, current or second variant format
// - tab character between log values
// - log field set follows compatibility mode
// - version string answered in any phase
module sci_top #(
  parameter BIT_CYCLES = `SCI_CLK_HZ / `SCI_BAUD
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // serial line
  input  wire        ser_rxd,
  output wire        ser_txd,
  // network byte stream
  input  wire [7:0]  net_rx_data,
  input  wire        net_rx_valid,
  output wire [7:0]  net_tx_data,
  output reg         net_tx_valid_q,
  input  wire        net_tx_ready,
  output reg  [15:0] net_port_q,
  // settings and mix phase
  input  wire [2:0]  proto_mode,
  input  wire        in_standby,
  // live readings, hundredths or tenths
  input  wire [15:0] moisture_val,
  input  wire [15:0] temp_val,
  input  wire [15:0] unscaled_val,
  input  wire [15:0] water_val,
  // recipe control
  output reg  [7:0]  recipe_next_q,
  output reg         recipe_sel_q,
  output reg  [15:0] dry_weight_q,
  output reg         dry_weight_wr_q,
  // mix log store
  input  wire [7:0]  log_count,
  output reg  [7:0]  log_rec_q,
  output reg  [6:0]  log_fld_q,
  output reg  [2:0]  log_fmt_q,
  input  wire [15:0] log_data
);
  localparam [2:0] PS_START  = 3'h0;
  localparam [2:0] PS_LETTER = 3'h1;
  localparam [2:0] PS_ONE    = 3'h2;
  localparam [2:0] PS_EQ     = 3'h3;
  localparam [2:0] PS_NUM    = 3'h4;

  localparam [2:0] RS_IDLE   = 3'h0;
  localparam [2:0] RS_TEXT   = 3'h1;
  localparam [2:0] RS_CR     = 3'h2;
  localparam [2:0] RS_NUM    = 3'h3;
  localparam [2:0] RS_SEP    = 3'h4;
  localparam [2:0] RS_LOAD   = 3'h5;
  localparam [2:0] RS_VER    = 3'h6;

  // one decimal digit of a 16-bit value
  function [3:0] dec_digit;
    input [15:0] v;
    input [2:0]  i;
    reg   [15:0] q;
    reg   [15:0] r;
    begin
      case (i)
        3'h0:    q = v;
        3'h1:    q = v / 16'h000A;
        3'h2:    q = v / 16'h0064;
        3'h3:    q = v / 16'h03E8;
        default: q = v / 16'h2710;
      endcase
      r         = q % 16'h000A;
      dec_digit = r[3:0];
    end
  endfunction

  // fields per record for a log format
  function [6:0] fld_total;
    input [2:0] fmt;
    begin
      case (fmt)
        `SCI_MODE_V1: fld_total = `SCI_FLD_V1;
        `SCI_MODE_V2: fld_total = `SCI_FLD_V2;
        `SCI_MODE_L5: fld_total = `SCI_FLD_L5;
        `SCI_MODE_L4: fld_total = `SCI_FLD_L4;
        default:      fld_total = `SCI_FLD_NATIVE;
      endcase
    end
  endfunction

  wire [7:0]  ser_rx_byte;
  wire        ser_rx_valid;
  wire        ser_tx_ready;
  reg         ser_tx_valid_q;
  reg  [7:0]  out_ch_q;
  reg         put_q;
  reg         resp_net_q;

  // parse state, the receive buffer of the current command
  reg  [2:0]  ps_stage_q;
  reg         ps_star_q;
  reg         ps_dry_q;
  reg         ps_bad_q;
  reg         ps_dig_q;
  reg         ps_over_q;
  reg  [17:0] ps_num_q;
  reg         exec_q;
  reg         src_net_q;

  // response state
  reg  [2:0]  rs_q;
  reg  [23:0] txt_q;
  reg  [1:0]  txt_n_q;
  reg  [15:0] num_val_q;
  reg  [2:0]  num_idx_q;
  reg  [2:0]  num_frac_q;
  reg         num_dot_q;
  reg         num_go_q;
  reg         num_log_q;
  reg         log_all_q;
  reg  [2:0]  ver_i_q;

  wire        ch_valid = ser_rx_valid | net_rx_valid;
  wire [7:0]  ch       = ser_rx_valid ? ser_rx_byte : net_rx_data;
  wire        ch_dig   = (ch >= `SCI_CH_ZERO) && (ch <= `SCI_CH_NINE);
  wire [17:0] num_x10  = {ps_num_q[14:0], 3'b000} + {ps_num_q[16:0], 1'b0}
                         + {14'h0000, ch[3:0]};
  wire        free     = !ser_tx_valid_q && !net_tx_valid_q && !put_q;
  wire        start_ex = (rs_q == RS_IDLE) && exec_q && free;
  wire [3:0]  cur_dig  = dec_digit(num_val_q, num_idx_q);
  wire [63:0] ver_sh   = `SCI_VERSION >> {~ver_i_q, 3'b000};
  wire [7:0]  ver_ch   = ver_sh[7:0];
  wire [7:0]  last_rec = log_count - 8'h01;
  wire [7:0]  next_rec = log_rec_q + 8'h01;
  wire [6:0]  next_fld = log_fld_q + 7'h01;

  assign net_tx_data = out_ch_q;

  // serial framing at the fixed rate
  sci_uart_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .clk        (clk),
    .rst        (rst),
    .rxd        (ser_rxd),
    .rx_byte_q  (ser_rx_byte),
    .rx_valid_q (ser_rx_valid)
  );

  sci_uart_tx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_tx (
    .clk        (clk),
    .rst        (rst),
    .tx_byte    (out_ch_q),
    .tx_valid   (ser_tx_valid_q),
    .tx_ready   (ser_tx_ready),
    .txd        (ser_txd)
  );

  // command assembly, one character at a time
  always @(posedge clk)
  begin
    if (rst || start_ex)
    begin
      // buffer cleared as the answer starts
      ps_stage_q <= PS_START;
      ps_star_q  <= 1'b0;
      ps_dry_q   <= 1'b0;
      ps_bad_q   <= 1'b0;
      ps_dig_q   <= 1'b0;
      ps_over_q  <= 1'b0;
      ps_num_q   <= 18'h0_0000;
      exec_q     <= 1'b0;
      if (rst)
        src_net_q <= 1'b0;
    end
    // a finished command holds off further input until it runs
    else if (ch_valid && !exec_q)
    begin
      if (ch == `SCI_CH_CR)
      begin
        exec_q    <= 1'b1;
        src_net_q <= !ser_rx_valid;
      end
      else
        case (ps_stage_q)
          PS_START:
            if (ch == `SCI_CH_GT)
              ps_stage_q <= PS_LETTER;
            else if (ch == `SCI_CH_STAR)
            begin
              ps_star_q  <= 1'b1;
              ps_stage_q <= PS_NUM;
            end
            else
              ps_bad_q <= 1'b1;
          PS_LETTER:
          begin
            ps_dry_q   <= (ch == `SCI_CH_D);
            ps_bad_q   <= ps_bad_q | ((ch != `SCI_CH_D) && (ch != `SCI_CH_R));
            ps_stage_q <= PS_ONE;
          end
          PS_ONE:
          begin
            ps_bad_q   <= ps_bad_q | (ch != `SCI_CH_ONE);
            ps_stage_q <= PS_EQ;
          end
          PS_EQ:
            if (ch == `SCI_CH_EQ)
              ps_stage_q <= PS_NUM;
            else if (ch != `SCI_CH_SP)
              ps_bad_q <= 1'b1;
          PS_NUM:
            if (ch_dig)
            begin
              ps_dig_q <= 1'b1;
              // flag ps_over_q rather than wrap, so huge values answer ?10
              if (ps_num_q > `SCI_NUM_SAT)
                ps_over_q <= 1'b1;
              else
                ps_num_q <= num_x10;
            end
            else if (ch != `SCI_CH_SP)
              ps_bad_q <= 1'b1;
          default:
            ps_bad_q <= 1'b1;
        endcase
    end
  end

  // output byte handshake to whichever channel asked
  always @(posedge clk)
  begin
    if (rst)
    begin
      ser_tx_valid_q <= 1'b0;
      net_tx_valid_q <= 1'b0;
      net_port_q     <= 16'h0000;
    end
    else
    begin
      net_port_q <= `SCI_TCP_PORT;
      if (put_q)
      begin
        ser_tx_valid_q <= !resp_net_q;
        net_tx_valid_q <= resp_net_q;
      end
      else
      begin
        if (ser_tx_ready)
          ser_tx_valid_q <= 1'b0;
        if (net_tx_ready)
          net_tx_valid_q <= 1'b0;
      end
    end
  end

  // decoding and reply generation
  always @(posedge clk)
  begin
    if (rst)
    begin
      rs_q            <= RS_IDLE;
      put_q           <= 1'b0;
      out_ch_q        <= 8'h00;
      resp_net_q      <= 1'b0;
      txt_q           <= 24'h00_0000;
      txt_n_q         <= 2'h0;
      num_val_q       <= 16'h0000;
      num_idx_q       <= 3'h0;
      num_frac_q      <= 3'h0;
      num_dot_q       <= 1'b0;
      num_go_q        <= 1'b0;
      num_log_q       <= 1'b0;
      log_all_q       <= 1'b0;
      ver_i_q         <= 3'h0;
      log_rec_q       <= 8'h00;
      log_fld_q       <= 7'h00;
      log_fmt_q       <= `SCI_MODE_NATIVE;
      recipe_next_q   <= 8'h00;
      recipe_sel_q    <= 1'b0;
      dry_weight_q    <= 16'h0000;
      dry_weight_wr_q <= 1'b0;
    end
    else
    begin
      put_q           <= 1'b0;
      recipe_sel_q    <= 1'b0;
      dry_weight_wr_q <= 1'b0;
      if (rs_q == RS_IDLE)
      begin
        if (start_ex)
        begin
          resp_net_q <= src_net_q;
          num_idx_q  <= 3'h4;
          num_dot_q  <= 1'b0;
          num_go_q   <= 1'b0;
          num_log_q  <= 1'b0;
          log_all_q  <= 1'b0;
          log_fld_q  <= 7'h00;
          ver_i_q    <= 3'h0;
          rs_q       <= RS_TEXT;
          txt_q      <= {`SCI_CH_QUERY, `SCI_CH_ONE, `SCI_ERR_CMD};
          txt_n_q    <= 2'h3;
          if (ps_bad_q || !ps_dig_q || ps_over_q || ps_stage_q != PS_NUM)
            rs_q <= RS_TEXT;
          else if (ps_star_q)
            case (ps_num_q)
              `SCI_Q_MOIST:
              begin
                num_val_q  <= moisture_val;
                num_frac_q <= 3'h2;
                rs_q       <= RS_NUM;
              end
              `SCI_Q_TEMP:
              begin
                num_val_q  <= temp_val;
                num_frac_q <= 3'h1;
                rs_q       <= RS_NUM;
              end
              `SCI_Q_RAW:
              begin
                num_val_q  <= unscaled_val;
                num_frac_q <= 3'h2;
                rs_q       <= RS_NUM;
              end
              `SCI_Q_WATER:
              begin
                num_val_q  <= water_val;
                num_frac_q <= 3'h1;
                rs_q       <= RS_NUM;
              end
              `SCI_Q_VER:
                rs_q <= RS_VER;
              // whole log from the oldest record
              `SCI_Q_LOG_ALL:
              begin
                log_all_q <= 1'b1;
                log_rec_q <= 8'h00;
                num_log_q <= 1'b1;
                log_fmt_q <= proto_mode;
                rs_q      <= (log_count == 8'h00) ? RS_CR : RS_LOAD;
              end
              `SCI_Q_LOG_LAST,
              `SCI_Q_LOG_V2:
              begin
                log_rec_q <= last_rec;
                num_log_q <= 1'b1;
                log_fmt_q <= (ps_num_q == `SCI_Q_LOG_V2) ? `SCI_MODE_V2 : proto_mode;
                rs_q      <= (log_count == 8'h00) ? RS_CR : RS_LOAD;
              end
              default:
                rs_q <= RS_TEXT;
            endcase
          else if (!in_standby)
            txt_q <= {`SCI_CH_QUERY, `SCI_CH_ONE, `SCI_ERR_PHASE};
          else if (ps_dry_q)
          begin
            if (ps_num_q == 18'h0_0000 || ps_num_q > `SCI_DRY_MAX)
              txt_q <= {`SCI_CH_QUERY, `SCI_CH_ONE, `SCI_ERR_ARG1};
            else
            begin
              dry_weight_q    <= ps_num_q[15:0];
              dry_weight_wr_q <= 1'b1;
              txt_q           <= {`SCI_CH_BANG, 16'h0000};
              txt_n_q         <= 2'h1;
            end
          end
          // recipe select; store makes blank one if missing
          else if (ps_num_q == 18'h0_0000 || ps_num_q > `SCI_RECIPE_MAX)
            txt_q <= {`SCI_CH_QUERY, `SCI_CH_ONE, `SCI_ERR_ARG1};
          else
          begin
            recipe_next_q <= ps_num_q[7:0];
            recipe_sel_q  <= 1'b1;
            txt_q         <= {`SCI_CH_BANG, 16'h0000};
            txt_n_q       <= 2'h1;
          end
        end
      end
      else if (free)
        case (rs_q)
          RS_TEXT:
          begin
            out_ch_q <= txt_q[23:16];
            put_q    <= 1'b1;
            txt_q    <= {txt_q[15:0], 8'h00};
            txt_n_q  <= txt_n_q - 2'h1;
            if (txt_n_q == 2'h1)
              rs_q <= RS_CR;
          end
          RS_VER:
          begin
            out_ch_q <= ver_ch;
            put_q    <= 1'b1;
            ver_i_q  <= ver_i_q + 3'h1;
            if (ver_i_q == 3'h7)
              rs_q <= RS_CR;
          end
          RS_CR:
          begin
            out_ch_q <= `SCI_CH_CR;
            put_q    <= 1'b1;
            rs_q     <= RS_IDLE;
          end
          RS_LOAD:
          begin
            // store answers the address one cycle after it moves
            num_val_q  <= log_data;
            num_frac_q <= 3'h0;
            num_idx_q  <= 3'h4;
            num_dot_q  <= 1'b0;
            num_go_q   <= 1'b0;
            rs_q       <= RS_NUM;
          end
          RS_NUM:
            if (num_frac_q != 3'h0 && !num_dot_q && num_idx_q == num_frac_q - 3'h1)
            begin
              out_ch_q  <= `SCI_CH_DOT;
              put_q     <= 1'b1;
              num_dot_q <= 1'b1;
            end
            else if (!num_go_q && cur_dig == 4'h0 && num_idx_q > num_frac_q)
              num_idx_q <= num_idx_q - 3'h1;
            else
            begin
              out_ch_q  <= {4'h3, cur_dig};
              put_q     <= 1'b1;
              num_go_q  <= 1'b1;
              num_idx_q <= num_idx_q - 3'h1;
              if (num_idx_q == 3'h0)
                rs_q <= num_log_q ? RS_SEP : RS_CR;
            end
          RS_SEP:
            if (next_fld < fld_total(log_fmt_q))
            begin
              out_ch_q  <= `SCI_CH_TAB;
              put_q     <= 1'b1;
              log_fld_q <= next_fld;
              rs_q      <= RS_LOAD;
            end
            else if (log_all_q && next_rec < log_count)
            begin
              out_ch_q  <= `SCI_CH_CR;
              put_q     <= 1'b1;
              log_rec_q <= next_rec;
              log_fld_q <= 7'h00;
              rs_q      <= RS_LOAD;
            end
            else
              rs_q <= RS_CR;
          default:
            rs_q <= RS_IDLE;
        endcase
    end
  end
endmodule

// File: logic/sci_consts.vh
// constants shared by the serial command interpreter files
`ifndef SCI_CONSTS_VH
`define SCI_CONSTS_VH

// clock and serial line framing
`define SCI_CLK_HZ      100000000
`define SCI_BAUD        9600
`define SCI_DATA_BITS   4'h8
`define SCI_FRAME_BITS  4'h9
`define SCI_TCP_PORT    16'h0017

// character codes
`define SCI_CH_CR       8'h0D
`define SCI_CH_TAB      8'h09
`define SCI_CH_SP       8'h20
`define SCI_CH_BANG     8'h21
`define SCI_CH_STAR     8'h2A
`define SCI_CH_DOT      8'h2E
`define SCI_CH_ZERO     8'h30
`define SCI_CH_ONE      8'h31
`define SCI_CH_NINE     8'h39
`define SCI_CH_EQ       8'h3D
`define SCI_CH_GT       8'h3E
`define SCI_CH_QUERY    8'h3F
`define SCI_CH_D        8'h44
`define SCI_CH_R        8'h52

// last digit of the ?1x error replies
`define SCI_ERR_CMD     8'h30
`define SCI_ERR_ARG1    8'h31
`define SCI_ERR_ARG2    8'h32
`define SCI_ERR_ARG3    8'h33
`define SCI_ERR_PHASE   8'h34

// query numbers after the star
`define SCI_Q_MOIST     18'h0_0002
`define SCI_Q_VER       18'h0_0003
`define SCI_Q_LOG_ALL   18'h0_0004
`define SCI_Q_TEMP      18'h0_0005
`define SCI_Q_RAW       18'h0_0007
`define SCI_Q_LOG_LAST  18'h0_0008
`define SCI_Q_LOG_V2    18'h0_0009
`define SCI_Q_WATER     18'h0_000A

// argument limits
`define SCI_RECIPE_MAX  18'h0_00FF
`define SCI_DRY_MAX     18'h0_7D00
`define SCI_NUM_SAT     18'h0_6665

// protocol compatibility modes
`define SCI_MODE_NATIVE 3'h0
`define SCI_MODE_V1     3'h1
`define SCI_MODE_V2     3'h2
`define SCI_MODE_L5     3'h3
`define SCI_MODE_L4     3'h4

// fields per log record for each mode
`define SCI_FLD_NATIVE  7'h42
`define SCI_FLD_V1      7'h30
`define SCI_FLD_V2      7'h42
`define SCI_FLD_L5      7'h14
`define SCI_FLD_L4      7'h14

// version text, eight characters, value arbitrary
`define SCI_VERSION     64'h7631_2E30_2E30_2E30

`endif

// File: logic/sci_uart_rx.v
// serial receiver, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
`include "sci_consts.vh"
module sci_uart_rx #(
  parameter BIT_CYCLES = 10416
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // line
  input  wire       rxd,
  // received byte
  output reg  [7:0] rx_byte_q,
  output reg        rx_valid_q
);
  localparam [15:0] BIT_LAST  = BIT_CYCLES - 1;
  localparam [15:0] BIT_HALF  = BIT_CYCLES / 2;
  localparam [1:0]  ST_IDLE   = 2'h0;
  localparam [1:0]  ST_START  = 2'h1;
  localparam [1:0]  ST_DATA   = 2'h2;
  localparam [1:0]  ST_STOP   = 2'h3;

  reg [1:0]  st_q;
  reg [15:0] cnt_q;
  reg [3:0]  nb_q;

  always @(posedge clk)
  begin
    if (rst)
    begin
      st_q       <= ST_IDLE;
      cnt_q      <= 16'h0000;
      nb_q       <= 4'h0;
      rx_byte_q  <= 8'h00;
      rx_valid_q <= 1'b0;
    end
    else
    begin
      rx_valid_q <= 1'b0;
      cnt_q      <= cnt_q + 16'h0001;
      case (st_q)
        ST_IDLE:
        begin
          cnt_q <= 16'h0000;
          if (!rxd)
            st_q <= ST_START;
        end
        ST_START:
          if (cnt_q == BIT_HALF)
          begin
            // glitch shorter than half a bit is not a start
            cnt_q <= 16'h0000;
            nb_q  <= 4'h0;
            st_q  <= rxd ? ST_IDLE : ST_DATA;
          end
        ST_DATA:
          if (cnt_q == BIT_LAST)
          begin
            cnt_q     <= 16'h0000;
            rx_byte_q <= {rxd, rx_byte_q[7:1]};
            nb_q      <= nb_q + 4'h1;
            if (nb_q == `SCI_DATA_BITS - 4'h1)
              st_q <= ST_STOP;
          end
        ST_STOP:
          if (cnt_q == BIT_LAST)
          begin
            // framing error drops the byte
            rx_valid_q <= rxd;
            st_q       <= ST_IDLE;
          end
        default:
          st_q <= ST_IDLE;
      endcase
    end
  end
endmodule

// File: logic/sci_uart_tx.v
// serial transmitter, 8 data bits, no parity, one stop bit
`timescale 1ns/1ns
`include "sci_consts.vh"
module sci_uart_tx #(
  parameter BIT_CYCLES = 10416
) (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // byte to send
  input  wire [7:0] tx_byte,
  input  wire       tx_valid,
  output wire       tx_ready,
  // line
  output wire       txd
);
  localparam [15:0] BIT_LAST = BIT_CYCLES - 1;

  reg [9:0]  sh_q;
  reg [15:0] cnt_q;
  reg [3:0]  nb_q;
  reg        busy_q;

  assign tx_ready = !busy_q;
  // idle line sits at the shifter's ones, so txd is a flop
  assign txd      = sh_q[0];

  always @(posedge clk)
  begin
    if (rst)
    begin
      sh_q   <= 10'h3FF;
      cnt_q  <= 16'h0000;
      nb_q   <= 4'h0;
      busy_q <= 1'b0;
    end
    else if (!busy_q)
    begin
      if (tx_valid)
      begin
        sh_q   <= {1'b1, tx_byte, 1'b0};
        cnt_q  <= 16'h0000;
        nb_q   <= 4'h0;
        busy_q <= 1'b1;
      end
    end
    else if (cnt_q == BIT_LAST)
    begin
      cnt_q <= 16'h0000;
      sh_q  <= {1'b1, sh_q[9:1]};
      nb_q  <= nb_q + 4'h1;
      if (nb_q == `SCI_FRAME_BITS)
        busy_q <= 1'b0;
    end
    else
      cnt_q <= cnt_q + 16'h0001;
  end
endmodule

// File: sim/sci_top_sva.sv
// assertions on the command interpreter ports
`timescale 1ns/1ns
module sci_top_sva (
  // clock and reset
  input wire        clk,
  input wire        rst,
  // network stream
  input wire [7:0]  net_rx_data,
  input wire        net_rx_valid,
  input wire [7:0]  net_tx_data,
  input wire        net_tx_valid_q,
  input wire        net_tx_ready,
  input wire [15:0] net_port_q,
  // phase and recipe
  input wire        in_standby,
  input wire        recipe_sel_q,
  input wire [15:0] dry_weight_q,
  input wire        dry_weight_wr_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr_w = recipe_sel_q | dry_weight_wr_q;
  wire take_w = net_tx_valid_q & net_tx_ready;

  a_port_fixed: assert property (!rst |=> net_port_q == 16'h0017)
    else $error("network port number wrong");
  // skipped leading zeros and the store fetch can delay the first byte
  a_reply_after_cr: assert property (net_rx_valid && net_rx_data == 8'h0D && !net_tx_valid_q
    |-> ##[3:9] net_tx_valid_q) else $error("no reply after carriage return");
  a_offer_holds: assert property (net_tx_valid_q && !net_tx_ready
    |=> net_tx_valid_q && $stable(net_tx_data)) else $error("reply byte dropped");
  a_write_standby: assert property (wr_w |-> in_standby)
    else $error("write taken outside standby");
  a_write_pulse: assert property (wr_w |=> !wr_w)
    else $error("write strobe too long");
  a_write_bang: assert property (wr_w |-> ##[1:3] (net_tx_valid_q && net_tx_data == 8'h21))
    else $error("write not acknowledged");
  a_dry_range: assert property (dry_weight_wr_q
    |-> dry_weight_q >= 16'h0001 && dry_weight_q <= 16'h7D00) else $error("dry weight range");
  a_bang_then_cr: assert property (take_w && net_tx_data == 8'h21
    |=> ##[0:4] (net_tx_valid_q && net_tx_data == 8'h0D)) else $error("no terminator");
  a_error_digit: assert property (take_w && net_tx_data == 8'h3F
    |=> ##[0:4] (net_tx_valid_q && net_tx_data == 8'h31)) else $error("bad error code");

  c_write: cover property (wr_w);
  c_error: cover property (take_w && net_tx_data == 8'h3F);
  c_tab: cover property (take_w && net_tx_data == 8'h09);
endmodule
bind sci_top sci_top_sva u_sci_top_sva (.clk, .rst, .net_rx_data, .net_rx_valid, .net_tx_data,
  .net_tx_valid_q, .net_tx_ready, .net_port_q, .in_standby, .recipe_sel_q, .dry_weight_q,
  .dry_weight_wr_q);

// File: sim/sci_host_model.sv
// host side model: mix log store and network sink
`timescale 1ns/1ns
module sci_host_model (
  // clock and reset
  input  wire        clk,
  input  wire        rst,
  // sink pacing
  input  wire        slow,
  output reg         net_tx_ready,
  // log store
  input  wire [7:0]  log_rec_q,
  input  wire [6:0]  log_fld_q,
  input  wire [2:0]  log_fmt_q,
  output wire [15:0] log_data
);
  // value carries format, record and field so any mix-up shows
  assign log_data = log_fmt_q * 16'h2710 + log_rec_q * 16'h0064 + log_fld_q;

  // slow sink stalls every other cycle
  always @(posedge clk)
  begin
    if (rst)
      net_tx_ready <= 1'b0;
    else
      net_tx_ready <= !slow | !net_tx_ready;
  end
endmodule

// File: sim/tb_top.sv
// self-checking bench for the serial command interpreter
`timescale 1ns/1ns
module tb_top;
  localparam BC = 16;
  reg        clk = 1'b0;
  reg        rst = 1'b1;
  reg        ser_rxd = 1'b1;
  reg [7:0]  net_rx_data = 8'h00;
  reg        net_rx_valid = 1'b0;
  reg [2:0]  proto_mode = 3'h0;
  reg        in_standby = 1'b1;
  reg [15:0] moisture_val = 16'h04D2;
  reg [15:0] temp_val = 16'h00EB;
  reg [15:0] unscaled_val = 16'h0005;
  reg [15:0] water_val = 16'h03E8;
  reg [7:0]  log_count = 8'h03;
  reg        slow = 1'b0;
  wire       ser_txd, net_tx_valid_q, net_tx_ready, recipe_sel_q, dry_weight_wr_q;
  wire [7:0] net_tx_data, recipe_next_q, log_rec_q;
  wire [15:0] net_port_q, dry_weight_q, log_data;
  wire [6:0] log_fld_q;
  wire [2:0] log_fmt_q;
  int        fail_count = 0;
  int        tests_run = 0;
  string     r;

  sci_top #(.BIT_CYCLES(BC)) u_sci_top (.clk, .rst, .ser_rxd, .ser_txd, .net_rx_data,
    .net_rx_valid, .net_tx_data, .net_tx_valid_q, .net_tx_ready, .net_port_q, .proto_mode,
    .in_standby, .moisture_val, .temp_val, .unscaled_val, .water_val, .recipe_next_q,
    .recipe_sel_q, .dry_weight_q, .dry_weight_wr_q, .log_count, .log_rec_q, .log_fld_q,
    .log_fmt_q, .log_data);
  sci_host_model u_sci_host_model (.clk, .rst, .slow, .net_tx_ready, .log_rec_q, .log_fld_q,
    .log_fmt_q, .log_data);

  always #5 clk = ~clk;

  task give_verdict;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task chk(input string n, input string e, input string g);
    tests_run++;
    if (e != g)
    begin
      $display("wrong value %s expected %s seen %s", n, e, g);
      fail_count++;
    end
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // sends one line, then gathers reply bytes until the sink goes quiet
  task automatic net_cmd(input string c);
    int idle;
    r = "";
    idle = 0;
    for (int i = 0; i <= c.len(); i++)
    begin
      net_rx_data = (i == c.len()) ? 8'h0D : c[i];
      net_rx_valid = 1'b1;
      wt(1);
    end
    net_rx_valid = 1'b0;
    net_rx_data = ~net_rx_data;
    while (idle < 200)
    begin
      @(negedge clk);
      idle++;
      if (net_tx_valid_q === 1'b1 && net_tx_ready === 1'b1)
      begin
        r = $sformatf("%s%c", r, net_tx_data);
        idle = 0;
      end
    end
    wt(1);
  endtask

  task run(input string c, input string e, input string n);
    net_cmd(c);
    chk(n, e, r);
  endtask

  function automatic string recs(int f, int lo, int hi, int n);
    string s;
    s = "";
    for (int k = lo; k <= hi; k++)
      for (int i = 0; i < n; i++)
        s = $sformatf("%s%0d%s", s, f * 10000 + k * 100 + i, (i == n - 1) ? "\r" : "\t");
    return s;
  endfunction

  task t_errors;
    run("XY", "?10\r", "unknown");
    run("", "?10\r", "empty line");
    run(">R1=0", "?11\r", "recipe zero");
    run(">D1=32001", "?11\r", "dry over");
  endtask

  task t_write;
    run(">R1=255", "!\r", "recipe ack");
    chk("recipe", "255", $sformatf("%0d", recipe_next_q));
    run(">D1 = 32000", "!\r", "dry ack");
    chk("dry", "32000", $sformatf("%0d", dry_weight_q));
    run(">D1=1", "!\r", "dry low ack");
    chk("dry low", "1", $sformatf("%0d", dry_weight_q));
  endtask

  task t_phase;
    in_standby = 1'b0;
    run(">R1=5", "?14\r", "recipe phase");
    chk("recipe kept", "255", $sformatf("%0d", recipe_next_q));
    run(">D1=100", "?14\r", "dry phase");
    chk("dry kept", "1", $sformatf("%0d", dry_weight_q));
  endtask

  task t_query;
    run("*2", "12.34\r", "moisture");
    run("*5", "23.5\r", "temperature");
    run("*7", "0.05\r", "unscaled");
    run("*10", "100.0\r", "water");
    net_cmd("*3");
    chk("version length", "9", $sformatf("%0d", r.len()));
    chk("version end", "\r", r.substr(r.len() - 1, r.len() - 1));
  endtask

  task t_log;
    int nf[5] = '{8'h42, 8'h30, 8'h42, 8'h14, 8'h14};
    slow = 1'b1;
    for (int m = 0; m < 5; m++)
    begin
      proto_mode = 3'(m);
      run("*8", recs(m, 2, 2, nf[m]), "last record");
    end
    run("*9", recs(2, 2, 2, 66), "variant record");
    log_count = 8'h02;
    proto_mode = 3'h3;
    run("*4", recs(3, 0, 1, 20), "full log");
    log_count = 8'h00;
    run("*4", "\r", "empty log");
    slow = 1'b0;
  endtask

  task ser_send(input byte b);
    ser_rxd = 1'b0;
    wt(BC);
    for (int i = 0; i < 8; i++)
    begin
      ser_rxd = b[i];
      wt(BC);
    end
    ser_rxd = 1'b1;
    wt(BC);
  endtask

  task ser_get(output byte b);
    // look off the edge so the start bit is not raced
    while (ser_txd !== 1'b0)
      wt(1);
    wt(BC / 2);
    for (int i = 0; i < 8; i++)
    begin
      wt(BC);
      b[i] = ser_txd;
    end
    wt(BC);
  endtask

  task t_serial;
    byte   b;
    string s;
    s = "";
    fork
      begin
        ser_send(8'h2A);
        ser_send(8'h32);
        ser_send(8'h0D);
      end
      repeat (6)
      begin
        ser_get(b);
        s = $sformatf("%s%c", s, b);
      end
    join
    chk("serial moisture", "12.34\r", s);
  endtask

  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    rst = 1'b0;
    wt(2);
    chk("port", "23", $sformatf("%0d", net_port_q));
    t_errors;
    t_write;
    t_phase;
    t_query;
    t_log;
    t_serial;
    give_verdict;
  end

  initial
  begin
    #900000;
    fail_count++;
    give_verdict;
  end
endmodule
